// file: hw/sasce_pkg.sv
// Constants, encodings and state type of the store, shift and compare unit
package sasce_pkg;
    // Instruction field encodings
    localparam logic [5:0] OP_GROUP = 6'h00;
    localparam logic [5:0] OP_STORE_RIGHT = 6'h2d;
    localparam logic [5:0] OP_STORE_HALF = 6'h29;
    localparam logic [5:0] FN_LEFT_IMM = 6'h00;
    localparam logic [5:0] FN_LEFT_VAR = 6'h04;
    localparam logic [5:0] FN_LESS_THAN = 6'h2a;
    // Memory access types
    localparam logic [2:0] TYPE_HALF = 3'h1;
    localparam logic [2:0] TYPE_DOUBLE = 3'h7;
    // Privilege encodings
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_USER = 2'h2;
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_GPR_SEL = 8'h08;
    localparam logic [7:0] REG_GPR_LO = 8'h0c;
    localparam logic [7:0] REG_GPR_HI = 8'h10;
    // Status bit positions, also used as fault codes
    localparam int ST_ADDR_ERR = 0;
    localparam int ST_RESERVED = 1;
    localparam int ST_XLAT_MISS = 2;
    localparam int ST_XLAT_INVALID = 3;
    localparam int ST_XLAT_MODIFY = 4;
    localparam int ST_BUS_ERR = 5;
    localparam int ST_W = 6;
    // Reset values
    localparam logic [ST_W-1:0] STATUS_RESET = 6'h00;
    localparam logic [ST_W-1:0] MASK_RESET = 6'h00;

    typedef struct packed {
        logic [31:0][63:0] general_reg_file;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [4:0] gpr_sel;
        logic [31:0] rd_data;
        logic store_valid;
        logic [63:0] store_virtual_addr;
        logic [2:0] store_offset;
        logic [2:0] store_type;
        logic [63:0] store_data;
        logic exc_valid;
        logic [2:0] exc_code;
    } sasce_state_t;
endpackage

// file: hw/sasce_core.sv
// Execute unit for right doubleword store, halfword store, shifts, compare
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module sasce_core (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic mode_64,
    input wire logic [1:0] priv_mode,
    input wire logic cpu_high_first_order,
    input wire logic memory_high_first_order,
    input wire logic user_order_flip,
    input wire logic xlat_miss,
    input wire logic xlat_invalid,
    input wire logic xlat_modify,
    input wire logic bus_error,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic store_valid,
    output logic [63:0] store_virtual_addr,
    output logic [2:0] store_offset,
    output logic [2:0] store_type,
    output logic [63:0] store_data,
    output logic exc_valid,
    output logic [2:0] exc_code,
    output logic irq
);
    import sasce_pkg::*;

    sasce_state_t st;
    sasce_state_t next_st;
    logic rst_meta;
    logic rst_n;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Field extraction
    logic [5:0] opcode;
    logic [5:0] funct;
    logic [4:0] primary_source_field;
    logic [4:0] second_source_field;
    logic [4:0] dest_field;
    logic [4:0] immediate_amount_field;
    logic [63:0] src_a;
    logic [63:0] src_b;
    assign opcode = instr[31:26];
    assign funct = instr[5:0];
    assign primary_source_field = instr[25:21];
    assign second_source_field = instr[20:16];
    assign dest_field = instr[15:11];
    assign immediate_amount_field = instr[10:6];
    assign src_a = st.general_reg_file[primary_source_field];
    assign src_b = st.general_reg_file[second_source_field];

    // Instruction decode
    logic store_right_double_op;
    logic store_halfsize_op;
    logic left_logical_imm_op;
    logic left_logical_var_op;
    logic signed_less_than_op;
    assign store_right_double_op = instr_valid && opcode == OP_STORE_RIGHT;
    assign store_halfsize_op = instr_valid && opcode == OP_STORE_HALF;
    assign left_logical_imm_op = instr_valid && opcode == OP_GROUP
        && funct == FN_LEFT_IMM;
    assign left_logical_var_op = instr_valid && opcode == OP_GROUP
        && funct == FN_LEFT_VAR && immediate_amount_field == 5'h00;
    assign signed_less_than_op = instr_valid && opcode == OP_GROUP
        && funct == FN_LESS_THAN;

    // Address generation from base and sign-extended offset
    logic [63:0] offset_ext;
    logic [63:0] sum64;
    logic [31:0] sum32;
    logic [63:0] virtual_addr;
    assign offset_ext = {{48{instr[15]}}, instr[15:0]};
    assign sum64 = src_a + offset_ext;
    assign sum32 = src_a[31:0] + offset_ext[31:0];
    assign virtual_addr = mode_64 ? sum64 : {{32{sum32[31]}}, sum32};

    // Right doubleword store lane, type and offset
    logic [2:0] right_byte;
    logic [2:0] right_type;
    logic [2:0] right_offset;
    logic [63:0] right_data;
    logic right_reserved;
    assign right_byte = virtual_addr[2:0] ^ {3{cpu_high_first_order}};
    assign right_type = cpu_high_first_order ? virtual_addr[2:0]
        : TYPE_DOUBLE - virtual_addr[2:0];
    assign right_offset = memory_high_first_order ? 3'h0
        : right_byte ^ {3{user_order_flip}};
    assign right_data = src_b << {right_byte, 3'b000};
    assign right_reserved = !mode_64 && (priv_mode == PRIV_SUPER
        || priv_mode == PRIV_USER);

    // Halfword store lane, offset and alignment
    logic [2:0] half_byte;
    logic [2:0] half_offset;
    logic [63:0] half_data;
    logic half_misaligned;
    assign half_byte = virtual_addr[2:0]
        ^ {cpu_high_first_order, cpu_high_first_order, 1'b0};
    assign half_offset = virtual_addr[2:0]
        ^ {user_order_flip, user_order_flip, 1'b0};
    assign half_data = {48'h0, src_b[15:0]} << {half_byte, 3'b000};
    assign half_misaligned = virtual_addr[0];

    // Left shifts with sign extension of the 32-bit result
    logic [4:0] shift_amount;
    logic [31:0] shifted;
    logic [63:0] shift_result;
    assign shift_amount = left_logical_var_op ? src_a[4:0]
        : immediate_amount_field;
    assign shifted = src_b[31:0] << shift_amount;
    assign shift_result = {{32{shifted[31]}}, shifted};

    // Signed compare without overflow detection
    logic less_than;
    assign less_than = mode_64 ? $signed(src_a) < $signed(src_b)
        : $signed(src_a[31:0]) < $signed(src_b[31:0]);

    // Register port decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = a == o;
    endfunction

    // Next state
    always_comb begin
        logic [ST_W-1:0] events;
        logic [ST_W-1:0] clear;
        logic wr_en;
        logic [63:0] wr_val;
        events = '0;
        clear = '0;
        wr_en = 1'b0;
        wr_val = '0;
        next_st = st;
        next_st.store_valid = 1'b0;
        next_st.exc_valid = 1'b0;
        next_st.rd_data = '0;
        events[ST_XLAT_MISS] = xlat_miss;
        events[ST_XLAT_INVALID] = xlat_invalid;
        events[ST_XLAT_MODIFY] = xlat_modify;
        events[ST_BUS_ERR] = bus_error;
        if (store_right_double_op) begin
            if (right_reserved) begin
                events[ST_RESERVED] = 1'b1;
                next_st.exc_valid = 1'b1;
                next_st.exc_code = 3'(ST_RESERVED);
            end else begin
                next_st.store_valid = 1'b1;
                next_st.store_virtual_addr = virtual_addr;
                next_st.store_offset = right_offset;
                next_st.store_type = right_type;
                next_st.store_data = right_data;
            end
        end
        if (store_halfsize_op) begin
            if (half_misaligned) begin
                events[ST_ADDR_ERR] = 1'b1;
                next_st.exc_valid = 1'b1;
                next_st.exc_code = 3'(ST_ADDR_ERR);
            end else begin
                next_st.store_valid = 1'b1;
                next_st.store_virtual_addr = virtual_addr;
                next_st.store_offset = half_offset;
                next_st.store_type = TYPE_HALF;
                next_st.store_data = half_data;
            end
        end
        if (left_logical_imm_op || left_logical_var_op) begin
            wr_en = 1'b1;
            wr_val = shift_result;
        end
        if (signed_less_than_op) begin
            wr_en = 1'b1;
            wr_val = {63'h0, less_than};
        end
        // Register port writes
        if (reg_write) begin
            if (hit(reg_addr, REG_STATUS)) begin
                clear = reg_wdata[ST_W-1:0];
            end
            if (hit(reg_addr, REG_MASK)) begin
                next_st.mask = reg_wdata[ST_W-1:0];
            end
            if (hit(reg_addr, REG_GPR_SEL)) begin
                next_st.gpr_sel = reg_wdata[4:0];
            end
            if (hit(reg_addr, REG_GPR_LO) && st.gpr_sel != 5'h00) begin
                next_st.general_reg_file[st.gpr_sel][31:0] = reg_wdata;
            end
            if (hit(reg_addr, REG_GPR_HI) && st.gpr_sel != 5'h00) begin
                next_st.general_reg_file[st.gpr_sel][63:32] = reg_wdata;
            end
        end
        // Instruction result wins over a port write
        if (wr_en && dest_field != 5'h00) begin
            next_st.general_reg_file[dest_field] = wr_val;
        end
        // Sticky status, set beats clear
        next_st.status = (st.status & ~clear) | events;
        // Register port reads, data one cycle later
        if (reg_read) begin
            if (hit(reg_addr, REG_STATUS)) begin
                next_st.rd_data = {26'h0, st.status};
            end else if (hit(reg_addr, REG_MASK)) begin
                next_st.rd_data = {26'h0, st.mask};
            end else if (hit(reg_addr, REG_GPR_SEL)) begin
                next_st.rd_data = {27'h0, st.gpr_sel};
            end else if (hit(reg_addr, REG_GPR_LO)) begin
                next_st.rd_data = st.general_reg_file[st.gpr_sel][31:0];
            end else if (hit(reg_addr, REG_GPR_HI)) begin
                next_st.rd_data = st.general_reg_file[st.gpr_sel][63:32];
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.status <= STATUS_RESET;
            st.mask <= MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign reg_rdata = st.rd_data;
    assign store_valid = st.store_valid;
    assign store_virtual_addr = st.store_virtual_addr;
    assign store_offset = st.store_offset;
    assign store_type = st.store_type;
    assign store_data = st.store_data;
    assign exc_valid = st.exc_valid;
    assign exc_code = st.exc_code;
    assign irq = |(st.status & st.mask);

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_right_ok;
        store_right_double_op && !right_reserved;
    endsequence
    sequence s_half_odd;
        store_halfsize_op && virtual_addr[0];
    endsequence
    sequence s_half_ok;
        store_halfsize_op && !virtual_addr[0];
    endsequence

    a_right_full_store: assert property (
        s_right_ok ##0 (!cpu_high_first_order && virtual_addr[2:0] == 3'h0)
        |=> store_valid && store_data == $past(src_b))
        else $error("right store at lane zero not full");
    a_right_type: assert property (
        s_right_ok |=> store_type == ($past(cpu_high_first_order)
            ? $past(virtual_addr[2:0]) : 3'h7 - $past(virtual_addr[2:0])))
        else $error("right store access type wrong");
    a_right_offset_bem: assert property (
        s_right_ok ##0 memory_high_first_order |=> store_offset == 3'h0)
        else $error("right store offset not zero for high-first memory");
    a_right_reserved: assert property (
        store_right_double_op && !mode_64 && priv_mode == PRIV_USER
        |=> exc_valid && exc_code == 3'h1 && !store_valid ##1 status_res())
        else $error("reserved fault missing for right store");
    a_half_addr: assert property (
        s_half_ok ##0 !mode_64 |=> store_virtual_addr[63:32] == {32{store_virtual_addr[31]}})
        else $error("halfword address not 32-bit in 32-bit mode");
    a_half_odd_err: assert property (
        s_half_odd |=> !store_valid && exc_valid && exc_code == 3'h0)
        else $error("odd halfword store not faulted");
    a_half_lane: assert property (
        s_half_ok ##0 !cpu_high_first_order && virtual_addr[2:0] == 3'h6
        |=> store_data[63:48] == $past(src_b[15:0])
            && store_type == TYPE_HALF)
        else $error("halfword lane placement wrong");
    a_shift_sext: assert property (
        left_logical_imm_op && dest_field != 5'h00
        |=> st.general_reg_file[$past(dest_field)][63:31] == {33{$past(shifted[31])}})
        else $error("shift result not sign-extended");
    a_slt_overflow: assert property (
        signed_less_than_op && mode_64 && dest_field != 5'h00
        && src_a[63] && !src_b[63]
        |=> st.general_reg_file[$past(dest_field)] == 64'h1 && !exc_valid)
        else $error("signed compare wrong under overflow");
    a_zero_reg: assert property (
        st.general_reg_file[0] == 64'h0)
        else $error("general register zero not zero");

    function automatic logic status_res();
        status_res = st.status[ST_RESERVED];
    endfunction
endmodule

// file: tb/sasce_mem_model.sv
// Memory side model: takes store requests, raises faults on command
`timescale 1ns/1ps
module sasce_mem_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic store_valid,
    input wire logic fault_en,
    input wire logic [1:0] fault_sel,
    output logic xlat_miss,
    output logic xlat_invalid,
    output logic xlat_modify,
    output logic bus_error
);
    logic [3:0] pulse;
    // One-cycle fault pulse after an accepted store when armed
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse <= 4'h0;
        end else begin
            pulse <= (store_valid && fault_en) ? 4'h1 << fault_sel : 4'h0;
        end
    end
    assign {bus_error, xlat_modify, xlat_invalid, xlat_miss} = pulse;
endmodule

// file: tb/testbench.sv
// Self-checking bench for the store, shift and compare unit
`timescale 1ns/1ps
module testbench;
    import sasce_pkg::*;
    logic ref_clk, arst_n, instr_valid, reg_write, reg_read, fault_en;
    logic mode_64, cpu_high_first_order, memory_high_first_order;
    logic user_order_flip, store_valid, exc_valid, irq;
    logic xlat_miss, xlat_invalid, xlat_modify, bus_error;
    logic [31:0] instr, reg_wdata, reg_rdata, d;
    logic [1:0] priv_mode, fault_sel;
    logic [7:0] reg_addr;
    logic [63:0] store_virtual_addr, store_data;
    logic [2:0] store_offset, store_type, exc_code;
    int n_mismatch, n_compared, cyc;
    typedef struct {logic [31:0] ins; logic [5:0] cfg; int kind;
        logic [63:0] val, va; logic [2:0] off, typ;} sasce_row_t;
    sasce_row_t rows[$];

    sasce_core sasce_core_inst (.ref_clk, .arst_n, .instr_valid, .instr,
        .mode_64, .priv_mode, .cpu_high_first_order,
        .memory_high_first_order, .user_order_flip, .xlat_miss,
        .xlat_invalid, .xlat_modify, .bus_error, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .store_valid, .store_virtual_addr,
        .store_offset, .store_type, .store_data, .exc_valid, .exc_code,
        .irq);
    sasce_mem_model sasce_mem_model_inst (.ref_clk, .arst_n, .store_valid,
        .fault_en, .fault_sel, .xlat_miss, .xlat_invalid, .xlat_modify,
        .bus_error);

    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic set_gpr(logic [4:0] n, logic [63:0] v);
        wr(REG_GPR_SEL, {27'h0, n});
        wr(REG_GPR_LO, v[31:0]);
        wr(REG_GPR_HI, v[63:32]);
    endtask
    task automatic chk_gpr(logic [4:0] n, logic [63:0] exp);
        logic [31:0] lo, hi;
        wr(REG_GPR_SEL, {27'h0, n});
        rd(REG_GPR_LO, lo);
        rd(REG_GPR_HI, hi);
        chk("gpr", {hi, lo}, exp);
    endtask
    task automatic exec(logic [31:0] i, logic [5:0] c);
        @(posedge ref_clk);
        {mode_64, priv_mode, cpu_high_first_order,
            memory_high_first_order, user_order_flip} <= c;
        instr_valid <= 1'b1;
        instr <= i;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] mi(logic [5:0] op, int b, int t,
        logic [15:0] o);
        return {op, b[4:0], t[4:0], o};
    endfunction
    function automatic logic [31:0] mr(int s, int t, int r, int a,
        logic [5:0] fn);
        return {OP_GROUP, s[4:0], t[4:0], r[4:0], a[4:0], fn};
    endfunction
    task automatic add(logic [31:0] i, logic [5:0] c, int k,
        logic [63:0] v, logic [63:0] a, logic [2:0] o, logic [2:0] t);
        rows.push_back('{i, c, k, v, a, o, t});
    endtask

    // Main sequence: table of instructions, then hand-written cases
    initial begin
        {arst_n, instr_valid, reg_write, reg_read, fault_en} = 5'h0;
        {mode_64, priv_mode, cpu_high_first_order} = 4'h0;
        {memory_high_first_order, user_order_flip, fault_sel} = 4'h0;
        {instr, reg_wdata, reg_addr} = '0;
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h3), 6'h20, 1,
            64'h4455667788000000, 64'h1003, 3'h3, 3'h4);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h5), 6'h26, 1,
            64'h3344556677880000, 64'h1005, 3'h0, 3'h5);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h0), 6'h21, 1,
            64'h1122334455667788, 64'h1000, 3'h7, 3'h7);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h7), 6'h20, 1,
            64'h8800000000000000, 64'h1007, 3'h7, 3'h0);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h7), 6'h04, 1,
            64'h1122334455667788, 64'h1007, 3'h0, 3'h7);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h0), 6'h10, 2, '0, '0, 3'h0, 3'h1);
        add(mi(OP_STORE_RIGHT, 2, 1, 16'h0), 6'h08, 2, '0, '0, 3'h0, 3'h1);
        add(mi(OP_STORE_HALF, 2, 1, 16'h6), 6'h20, 1,
            64'h7788000000000000, 64'h1006, 3'h6, 3'h1);
        add(mi(OP_STORE_HALF, 2, 1, 16'h2), 6'h25, 1,
            64'h0000778800000000, 64'h1002, 3'h4, 3'h1);
        add(mi(OP_STORE_HALF, 6, 1, 16'hfffe), 6'h10, 1,
            64'h7788000000000000, 64'hfffffffffffffffe, 3'h6, 3'h1);
        add(mi(OP_STORE_HALF, 6, 1, 16'hfffe), 6'h20, 1,
            64'h7788000000000000, 64'h7ffffffffffffffe, 3'h6, 3'h1);
        add(mi(OP_STORE_HALF, 2, 1, 16'h1), 6'h20, 2, '0, '0, 3'h0, 3'h0);
        add(mr(0, 1, 7, 8, FN_LEFT_IMM), 6'h20, 0, 64'h66778800, '0, 0, 0);
        add(mr(0, 1, 7, 1, FN_LEFT_IMM), 6'h20, 0, 64'hffffffffaaccef10,
            '0, 3'h0, 3'h0);
        add(mr(0, 3, 8, 0, FN_LEFT_IMM), 6'h20, 0, 64'hffffffff80000001,
            '0, 3'h0, 3'h0);
        add(mr(0, 3, 8, 31, FN_LEFT_IMM), 6'h20, 0, 64'hffffffff80000000,
            '0, 3'h0, 3'h0);
        add(mr(4, 1, 9, 0, FN_LEFT_VAR), 6'h20, 0, 64'h56677880, '0, 0, 0);
        add(mr(4, 1, 10, 3, FN_LEFT_VAR), 6'h20, 0, '0, '0, 3'h0, 3'h0);
        add(mr(6, 5, 11, 0, FN_LESS_THAN), 6'h20, 0, 64'h1, '0, 0, 0);
        add(mr(5, 6, 11, 0, FN_LESS_THAN), 6'h20, 0, '0, '0, 3'h0, 3'h0);
        add(mr(6, 5, 0, 0, FN_LESS_THAN), 6'h20, 0, '0, '0, 3'h0, 3'h0);
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(REG_STATUS, d);
        chk("status", d, '0);
        rd(REG_MASK, d);
        chk("mask", d, '0);
        set_gpr(5'd1, 64'h1122334455667788);
        set_gpr(5'd2, 64'h1000);
        set_gpr(5'd3, 64'h80000001);
        set_gpr(5'd4, 64'h4);
        set_gpr(5'd5, 64'h7fffffffffffffff);
        set_gpr(5'd6, 64'h8000000000000000);
        foreach (rows[j]) begin
            exec(rows[j].ins, rows[j].cfg);
            chk("store_valid", store_valid, rows[j].kind == 1);
            chk("exc_valid", exc_valid, rows[j].kind == 2);
            if (rows[j].kind == 1) begin
                chk("store_data", store_data, rows[j].val);
                chk("store_virtual_addr", store_virtual_addr, rows[j].va);
                chk("store_offset", store_offset, rows[j].off);
                chk("store_type", store_type, rows[j].typ);
            end else if (rows[j].kind == 2) begin
                chk("exc_code", exc_code, rows[j].typ);
            end else begin
                chk_gpr(rows[j].ins[15:11], rows[j].val);
            end
        end
        // Back-to-back: compare reads the shift result of the cycle before
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= mr(0, 1, 12, 8, FN_LEFT_IMM);
        @(posedge ref_clk);
        instr <= mr(12, 4, 13, 0, FN_LESS_THAN);
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        chk_gpr(5'd13, '0);
        // Sticky status, mask and level interrupt
        rd(REG_STATUS, d);
        chk("status", d, 64'h3);
        chk("irq", irq, 1'b0);
        wr(REG_MASK, 32'h2);
        chk("irq", irq, 1'b1);
        wr(REG_STATUS, 32'h2);
        chk("irq", irq, 1'b0);
        wr(REG_STATUS, 32'h1);
        wr(REG_MASK, 32'h3c);
        fault_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            fault_sel <= k[1:0];
            exec(mi(OP_STORE_HALF, 2, 1, 16'h6), 6'h20);
            repeat (2) @(posedge ref_clk);
            rd(REG_STATUS, d);
            chk("status", d, 32'h4 << k);
            chk("irq", irq, 1'b1);
            wr(REG_STATUS, 32'h4 << k);
            chk("irq", irq, 1'b0);
        end
        fault_en <= 1'b0;
        wr(8'h20, 32'hffffffff);
        rd(8'h20, d);
        chk("unmapped", d, '0);
        // Reset in mid-run clears registers and GPRs
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(REG_MASK, d);
        chk("mask", d, '0);
        chk_gpr(5'd7, '0);
        results();
    end
endmodule
